//--- inc/pcrs_pkg.sv
// Package: register offsets, field positions and reset values of the port register bank
package pcrs_pkg;
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 16;
  localparam int          CUR_W        = 12;
  // Register offsets within one port's address block
  localparam logic [3:0]  OFS_CFG0     = 4'h3;
  localparam logic [3:0]  OFS_RESULT   = 4'h6;
  localparam logic [3:0]  OFS_DIAG     = 4'h7;
  // Field positions
  localparam int          CUR_LSB      = 0;
  localparam int          NEW_BIT      = 12;
  localparam int          MISS_BIT     = 13;
  localparam int          FPOS_BIT     = 0;
  localparam int          FNEG_BIT     = 1;
  localparam int          FOLD_DIS_BIT = 9;
  // Reset values
  localparam logic [11:0] CUR_RST      = 12'h000;
  localparam logic [15:0] RDATA_RST    = 16'h0000;
  localparam logic        FLAG_RST     = 1'b0;

  // Whole state of the register bank
  typedef struct packed {
    logic [11:0] cur;
    logic        fresh;
    logic        missed;
    logic        f_pos;
    logic        f_neg;
    logic        fold_dis;
    logic [15:0] rdata;
  } pcrs_regs_t;

  // State of the foldback stage
  typedef struct packed {
    logic active;
  } pcrs_fold_t;
endpackage : pcrs_pkg

//--- inc/pcrs_fold_if.sv
// Interface: signals between the register bank and the foldback stage
`timescale 1ns/10ps
interface pcrs_fold_if;
  logic vds_high;     // Drain-source above threshold
  logic fold_dis;     // Foldback suppressed by software
  logic fold_active;  // Current limit lowered

  modport ctl (output vds_high, output fold_dis, input fold_active);
  modport fb  (input vds_high, input fold_dis, output fold_active);
endinterface : pcrs_fold_if

//--- hw/pcrs_foldback.sv
// Foldback stage: decides when the port current limit is lowered
`timescale 1ns/10ps
module pcrs_foldback (
  input  wire logic CLK_SYS, // System clock
  input  wire logic RST,     // Asynchronous reset, active high
  pcrs_fold_if.fb   fold     // Comparator in, control in, foldback out
);
  pcrs_pkg::pcrs_fold_t st_r;
  pcrs_pkg::pcrs_fold_t st_nxt;

  // Lower the limit while the transistor sees high voltage, unless disabled
  always_comb begin
    st_nxt        = st_r;
    st_nxt.active = fold.vds_high & ~fold.fold_dis;
  end

  // State register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fold.fold_active = st_r.active;
endmodule : pcrs_foldback

//--- hw/pcrs_port_regs.sv
// Port register bank: current readout, diagnosis forcing and foldback control
// Overview of operation
// - A fresh current result from the port converter sets the new-result flag, bit 12.
// - A result that replaces one the host never read sets the overrun flag, bit 13.
// - The latest current sits in bits 11..0 of the read-only result register; bits 15..14 read 0.
// - A one in bit 1 of the diagnosis register makes the negative output look power-bad.
// - A one in bit 0 of the diagnosis register makes the positive output look power-bad.
// - The current limit folds back when drain-source is above 12 V, unless config bit 9 is set.
`timescale 1ns/10ps
module pcrs_port_regs (
  input  wire logic        CLK_SYS,         // System clock, 250 MHz
  input  wire logic        RST,             // Asynchronous reset, active high
  input  wire logic [3:0]  REG_ADDR,        // Register offset within the port
  input  wire logic        REG_WR,          // Write strobe, one cycle
  input  wire logic        REG_RD,          // Read strobe, one cycle
  input  wire logic [15:0] REG_WDATA,       // Write data
  output logic      [15:0] REG_RDATA,       // Read data, valid the cycle after REG_RD
  input  wire logic        ADC_VALID,       // Converter stores a new result, one cycle
  input  wire logic [11:0] ADC_DATA,        // Converter source-current result
  input  wire logic        POS_PGOOD_RAW,   // Positive output power-good comparator
  input  wire logic        NEG_PGOOD_RAW,   // Negative output power-good comparator
  input  wire logic        VDS_HIGH,        // Drain-source above 12 V comparator
  output logic             POS_PGOOD,       // Positive output power-good after forcing
  output logic             NEG_PGOOD,       // Negative output power-good after forcing
  output logic             FOLDBACK_ACTIVE  // Current limit lowered
);
  pcrs_pkg::pcrs_regs_t st_r;
  pcrs_pkg::pcrs_regs_t st_nxt;
  logic                 rd_result;
  logic                 rd_diag;
  logic                 rd_cfg;
  logic                 wr_diag;
  logic                 wr_cfg;

  pcrs_fold_if fold ();

  // Address decode of the host strobes
  assign rd_result = REG_RD && (REG_ADDR == pcrs_pkg::OFS_RESULT);
  assign rd_diag   = REG_RD && (REG_ADDR == pcrs_pkg::OFS_DIAG);
  assign rd_cfg    = REG_RD && (REG_ADDR == pcrs_pkg::OFS_CFG0);
  assign wr_diag   = REG_WR && (REG_ADDR == pcrs_pkg::OFS_DIAG);
  assign wr_cfg    = REG_WR && (REG_ADDR == pcrs_pkg::OFS_CFG0);

  // Next state of the register bank
  always_comb begin
    st_nxt = st_r;
    // A read consumes the flags; a result in the same cycle sets the new-result flag again, not the overrun flag
    if (rd_result) begin
      st_nxt.fresh  = 1'b0;
      st_nxt.missed = 1'b0;
    end
    if (ADC_VALID) begin
      st_nxt.cur   = ADC_DATA;
      st_nxt.fresh = 1'b1;
      if (st_r.fresh && !rd_result) begin
        st_nxt.missed = 1'b1;
      end
    end
    // Diagnosis and configuration writes
    if (wr_diag) begin
      st_nxt.f_pos = REG_WDATA[pcrs_pkg::FPOS_BIT];
      st_nxt.f_neg = REG_WDATA[pcrs_pkg::FNEG_BIT];
    end
    if (wr_cfg) begin
      st_nxt.fold_dis = REG_WDATA[pcrs_pkg::FOLD_DIS_BIT];
    end
    // Read data: unmapped offsets and reserved bits return zero
    st_nxt.rdata = pcrs_pkg::RDATA_RST;
    if (rd_result) begin
      st_nxt.rdata[pcrs_pkg::CUR_LSB +: pcrs_pkg::CUR_W] = st_r.cur;
      st_nxt.rdata[pcrs_pkg::NEW_BIT]                    = st_r.fresh;
      st_nxt.rdata[pcrs_pkg::MISS_BIT]                   = st_r.missed;
    end else if (rd_diag) begin
      st_nxt.rdata[pcrs_pkg::FPOS_BIT] = st_r.f_pos;
      st_nxt.rdata[pcrs_pkg::FNEG_BIT] = st_r.f_neg;
    end else if (rd_cfg) begin
      st_nxt.rdata[pcrs_pkg::FOLD_DIS_BIT] = st_r.fold_dis;
    end
  end

  // State register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_r.cur      <= pcrs_pkg::CUR_RST;
      st_r.fresh    <= pcrs_pkg::FLAG_RST;
      st_r.missed   <= pcrs_pkg::FLAG_RST;
      st_r.f_pos    <= pcrs_pkg::FLAG_RST;
      st_r.f_neg    <= pcrs_pkg::FLAG_RST;
      st_r.fold_dis <= pcrs_pkg::FLAG_RST;
      st_r.rdata    <= pcrs_pkg::RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Foldback stage
  assign fold.vds_high = VDS_HIGH;
  assign fold.fold_dis = st_r.fold_dis;

  pcrs_foldback u_fold (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .fold    (fold.fb)
  );

  // Outputs; forcing masks the comparators so the port reacts as to a real fault
  assign REG_RDATA       = st_r.rdata;
  assign POS_PGOOD       = POS_PGOOD_RAW & ~st_r.f_pos;
  assign NEG_PGOOD       = NEG_PGOOD_RAW & ~st_r.f_neg;
  assign FOLDBACK_ACTIVE = fold.fold_active;

  // Checks on the register bank
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_result_read;
    rd_result && !ADC_VALID;
  endsequence

  sequence s_flags_cleared;
    !st_r.fresh && !st_r.missed;
  endsequence

  sequence s_fresh_pending;
    st_r.fresh && !rd_result;
  endsequence

  AST_NEW_SET: assert property (ADC_VALID |=> st_r.fresh)
    else $error("new-result flag not set after a converter result");

  AST_MISS_SET: assert property ((ADC_VALID and s_fresh_pending) |=> st_r.missed)
    else $error("overrun flag not set when an unread result was replaced");

  AST_NO_FALSE_MISS: assert property (!st_r.missed && !ADC_VALID |=> !st_r.missed)
    else $error("overrun flag set without a replaced result");

  AST_CUR_LOAD: assert property (ADC_VALID ##1 rd_result |=>
      REG_RDATA[11:0] == $past(ADC_DATA, 2))
    else $error("read data does not show the last current result");

  AST_RSV_ZERO: assert property (REG_RDATA[15:14] == 2'b00)
    else $error("reserved bits of read data not zero");

  AST_NEG_FORCE: assert property ($rose(st_r.f_neg) |-> !NEG_PGOOD
      && $past(wr_diag) && $past(REG_WDATA[1]))
    else $error("negative output forcing wrong");

  AST_POS_FORCE: assert property (wr_diag && REG_WDATA[0] |=> !POS_PGOOD)
    else $error("positive output not forced to power-bad");

  AST_FOLD: assert property (##1 FOLDBACK_ACTIVE ==
      ($past(VDS_HIGH) && !$past(st_r.fold_dis)))
    else $error("foldback does not follow drain-source and disable bit");

  AST_RD_CLEAR: assert property (s_result_read |=> s_flags_cleared
      and (REG_RDATA[pcrs_pkg::NEW_BIT] == $past(st_r.fresh)))
    else $error("reading the result did not clear the flags");

  // Steps of a result arriving alongside a read of the result register
  sequence s_read_with_result;
    rd_result && ADC_VALID;
  endsequence

  sequence s_fresh_only;
    st_r.fresh && !st_r.missed;
  endsequence

  // Flags hold until a read, and never rise without a result
  AST_NEW_KEEP: assert property (st_r.fresh && !rd_result |=> st_r.fresh)
    else $error("new-result flag lost without a read");

  AST_NO_FALSE_NEW: assert property (!st_r.fresh && !ADC_VALID |=> !st_r.fresh)
    else $error("new-result flag set without a converter result");

  AST_MISS_KEEP: assert property (st_r.missed && !rd_result |=> st_r.missed)
    else $error("overrun flag lost without a read");

  AST_MISS_OUT: assert property (rd_result |=>
      REG_RDATA[pcrs_pkg::MISS_BIT] == $past(st_r.missed))
    else $error("read data does not show the overrun flag");

  // Stored current follows the converter and nothing else
  AST_CUR_STORE: assert property (ADC_VALID |=> st_r.cur == $past(ADC_DATA))
    else $error("converter result not stored");

  AST_CUR_HOLD: assert property (!ADC_VALID |=> $stable(st_r.cur))
    else $error("stored current changed without a converter result");

  AST_RDATA_IDLE: assert property (!REG_RD |=> REG_RDATA == pcrs_pkg::RDATA_RST)
    else $error("read data not zero in a cycle without a read");

  // Diagnosis bits follow the host and mask only while set
  AST_DIAG_WR: assert property (wr_diag |=>
      st_r.f_pos == $past(REG_WDATA[pcrs_pkg::FPOS_BIT])
      && st_r.f_neg == $past(REG_WDATA[pcrs_pkg::FNEG_BIT]))
    else $error("diagnosis write not taken");

  AST_DIAG_RD: assert property (rd_diag |=>
      REG_RDATA[pcrs_pkg::FNEG_BIT] == $past(st_r.f_neg)
      && REG_RDATA[pcrs_pkg::FPOS_BIT] == $past(st_r.f_pos))
    else $error("diagnosis read back wrong");

  AST_NEG_PASS: assert property (!st_r.f_neg |-> NEG_PGOOD == NEG_PGOOD_RAW)
    else $error("negative power-good masked while not forced");

  AST_POS_PASS: assert property (!st_r.f_pos |-> POS_PGOOD == POS_PGOOD_RAW)
    else $error("positive power-good masked while not forced");

  // Disable bit reads back and keeps the limit up
  AST_CFG_RD: assert property (rd_cfg |=>
      REG_RDATA[pcrs_pkg::FOLD_DIS_BIT] == $past(st_r.fold_dis))
    else $error("foldback disable bit read back wrong");

  AST_FOLD_OFF: assert property (st_r.fold_dis |=> !FOLDBACK_ACTIVE)
    else $error("foldback active while disabled");

  // A result racing a read leaves a fresh flag and no overrun
  AST_RD_RACE: assert property (s_read_with_result |=> s_fresh_only)
    else $error("result beside a read left wrong flags");
endmodule : pcrs_port_regs

//--- bench/pcrs_host.sv
// Host model: drives register strobes one cycle at a time
`timescale 1ns/10ps
module pcrs_host (
  input  wire logic        clk,   // System clock
  output logic      [3:0]  addr,  // Register offset
  output logic             wr,    // Write strobe
  output logic             rd,    // Read strobe
  output logic      [15:0] wdata  // Write data
);
  initial begin
    addr = 4'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end
  // One write cycle; data turns over once released
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask : wr_reg
  // One read cycle
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
  endtask : rd_reg
endmodule : pcrs_host

//--- bench/tb_top.sv
// Testbench: current readout flags, diagnosis forcing and foldback control
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr;
  logic        reg_wr, reg_rd, pos_pg, neg_pg, fold;
  logic [15:0] reg_wdata, reg_rdata, exp_v;
  logic        adc_valid = 1'b0;
  logic [11:0] adc_data = 12'h000;
  logic        vds_high = 1'b0;
  logic        pos_raw = 1'b1;
  logic        neg_raw = 1'b1;
  logic        rd_d = 1'b0;
  logic [15:0] exp_q[$];
  integer      seed = 32'hc5d7;
  integer      error_cnt = 0;
  integer      check_count = 0;

  always #2 clk_sys = ~clk_sys;

  pcrs_port_regs dut (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .ADC_VALID(adc_valid),
    .ADC_DATA(adc_data), .POS_PGOOD_RAW(pos_raw), .NEG_PGOOD_RAW(neg_raw), .VDS_HIGH(vds_high),
    .POS_PGOOD(pos_pg), .NEG_PGOOD(neg_pg), .FOLDBACK_ACTIVE(fold));
  pcrs_host host (.clk(clk_sys), .addr(reg_addr), .wr(reg_wr), .rd(reg_rd), .wdata(reg_wdata));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, want, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Note the expected answer, then issue the read
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd_reg(a);
  endtask : rd

  // Back-to-back converter results with random values; last one returned
  task automatic pulse(input int n, output logic [11:0] d);
    repeat (n) begin
      @(posedge clk_sys);
      d = 12'($random(seed));
      adc_valid <= 1'b1;
      adc_data  <= d;
    end
    @(posedge clk_sys);
    adc_valid <= 1'b0;
    adc_data  <= ~d;
  endtask : pulse

  // Read answers stand one cycle after the strobe; compare mid-cycle
  always @(negedge clk_sys) begin
    if (rd_d) begin
      exp_v = exp_q.pop_front();
      check("rdata", reg_rdata, exp_v);
    end
  end
  always @(posedge clk_sys) rd_d <= reg_rd;

  initial begin
    logic [11:0] d, d2;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h6, 16'h0000);
    #1 check("fold", {15'h0000, fold}, 16'h0000);
    pulse(1, d);
    rd(4'h6, {4'b0001, d});
    rd(4'h6, {4'b0000, d});
    pulse(3, d);
    rd(4'h6, {4'b0011, d});
    host.wr_reg(4'h6, 16'hffff);
    rd(4'h6, {4'b0000, d});
    rd(4'h0, 16'h0000);
    // Result and read in one cycle: old value read, new flag kept, no overrun
    @(posedge clk_sys);
    d = 12'($random(seed));
    adc_valid <= 1'b1;
    adc_data  <= d;
    fork
      pulse(1, d2);
      rd(4'h6, {4'b0001, d});
    join
    rd(4'h6, {4'b0001, d2});
    // Every forcing combination, then read it back
    for (int i = 0; i < 4; i++) begin
      {pos_raw, neg_raw} <= 2'($random(seed));
      host.wr_reg(4'h7, 16'(i));
      #1 check("pos_pg", {15'h0000, pos_pg}, {15'h0000, pos_raw & ~i[0]});
      check("neg_pg", {15'h0000, neg_pg}, {15'h0000, neg_raw & ~i[1]});
      rd(4'h7, 16'(i));
    end
    // Foldback follows the comparator unless disabled
    host.wr_reg(4'h3, 16'h0000);
    vds_high <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check("fold", {15'h0000, fold}, 16'h0001);
    host.wr_reg(4'h3, 16'h0200);
    rd(4'h3, 16'h0200);
    #1 check("fold", {15'h0000, fold}, 16'h0000);
    repeat (3) @(posedge clk_sys);
    check("queue", 16'(exp_q.size()), 16'h0000);
    tally_and_finish();
  end

  // Watchdog well beyond the fewer than a hundred cycles the sequence needs
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb_top
